// ### verilog/vcs_pkg.sv
package vcs_pkg;
  // port counts; MAX_OUT sizes storage, the build picks 4 or 8 outputs
  localparam int NUM_IN = 8;
  localparam int MAX_OUT = 8;
  localparam logic [3:0] NO_INPUT = 4'h0;

  // register byte offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] ROUTE_OFS = 8'h04;
  localparam logic [7:0] FLAGS_OFS = 8'h08;
  localparam logic [7:0] PROTECT_OFS = 8'h0c;
  localparam logic [7:0] ACK_OFS = 8'h10;
  localparam logic [7:0] INT_STATUS_OFS = 8'h14;
  localparam logic [7:0] INT_MASK_OFS = 8'h18;
  localparam logic [7:0] REPORT_SEL_OFS = 8'h1c;
  localparam logic [7:0] REPORT_OFS = 8'h20;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_IN_LSB = 4;
  localparam int CMD_OUT_LSB = 8;
  localparam int CMD_VAL_BIT = 12;
  localparam int ACK_REFUSED_BIT = 16;

  typedef enum logic [3:0] {
    VCS_SWITCH,
    VCS_ROUTE_EVERY_OUTPUT,
    VCS_SILENCE_INPUT,
    VCS_UNSILENCE_INPUT,
    VCS_SILENCE_OUTPUT,
    VCS_UNSILENCE_OUTPUT,
    VCS_FREEZE_INPUT,
    VCS_UNFREEZE_INPUT,
    VCS_FREEZE_OUTPUT,
    VCS_UNFREEZE_OUTPUT,
    VCS_SET_INPUT_PROTECT,
    VCS_SET_OUTPUT_PROTECT
  } vcs_op_e;

  // two-bit status field codes
  localparam logic [1:0] FLD_UNKNOWN = 2'h0;
  localparam logic [1:0] FLD_ABSENT = 2'h2;
  localparam logic [1:0] FLD_PRESENT = 2'h3;
  localparam logic [7:0] RSV_BYTE = 8'h00;

  // status letters, ascii
  localparam logic [7:0] LET_FREE = 8'h54;
  localparam logic [7:0] LET_LOCKED = 8'h4c;
  localparam logic [7:0] LET_MUTED = 8'h4d;
  localparam logic [7:0] LET_BOTH = 8'h55;

  // interrupt bits
  localparam int INT_DONE = 0;
  localparam int INT_ROUTE = 1;
  localparam int INT_REFUSED = 2;

  // reset values
  localparam logic [2:0] INT_MASK_RST = 3'h0;
  localparam logic [7:0] IN_PROTECT_RST = 8'hff;
  localparam logic [7:0] OUT_PROTECT_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### verilog/vcs_xpoint.sv
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module vcs_xpoint #(
  parameter int NUM_OUT = 8
) (
  input wire logic clk, // 25 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [31:0] stat_known, // per input x4 aspects, known
  input wire logic [31:0] stat_present, // per input x4 aspects, present
  output logic [31:0] route_out, // input number per output, 0 = none
  output logic [7:0] blank_out, // per output video blank
  output logic irq // level interrupt
);

  typedef struct packed {
    logic [7:0][3:0] route;
    logic [7:0] in_mute;
    logic [7:0] in_lock;
    logic [7:0] out_mute;
    logic [7:0] out_lock;
    logic [7:0] in_prot;
    logic [7:0] out_mode;
    logic [7:0] blank;
    logic [2:0] ist;
    logic [2:0] imask;
    logic [2:0] rsel;
    logic [12:0] ack_echo;
    logic ack_ref;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vcs_state_s;

  vcs_state_s q;
  vcs_state_s next_q;
  logic wr_fire;
  logic do_cmd;
  logic [31:0] cmd;
  logic [3:0] cop;
  logic [3:0] cin;
  logic [3:0] cout;
  logic [31:0] rep_word;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] letter(input logic mute, input logic lock);
    case ({mute, lock})
      2'b00: letter = vcs_pkg::LET_FREE;
      2'b01: letter = vcs_pkg::LET_LOCKED;
      2'b10: letter = vcs_pkg::LET_MUTED;
      default: letter = vcs_pkg::LET_BOTH;
    endcase
  endfunction

  function automatic logic [1:0] enc(input logic known, input logic pres);
    if (!known) begin
      enc = vcs_pkg::FLD_UNKNOWN;
    end else if (pres) begin
      enc = vcs_pkg::FLD_PRESENT;
    end else begin
      enc = vcs_pkg::FLD_ABSENT;
    end
  endfunction

  function automatic logic in_range(input logic [3:0] v, input int hi);
    in_range = (v != 4'h0) && (int'(v) <= hi);
  endfunction

  always_comb begin
    logic [2:0] ii;
    logic [2:0] oi;
    logic [2:0] ri;
    logic [2:0] sel;
    logic [7:0] waddr;
    logic [7:0] raddr;
    logic [2:0] clr;
    logic [2:0] set;
    logic ref_flag;
    ii = 3'h0;
    oi = 3'h0;
    ri = 3'h0;
    sel = q.rsel;
    waddr = {q.aw_addr[7:2], 2'b00};
    raddr = {s_axi_araddr[7:2], 2'b00};
    clr = 3'h0;
    set = 3'h0;
    ref_flag = 1'b0;
    next_q = q;

    // input report for the selected port
    rep_word = {8'h00, letter(q.in_mute[sel], q.in_lock[sel]),
                vcs_pkg::RSV_BYTE,
                enc(stat_known[4*sel+3], stat_present[4*sel+3]),
                enc(stat_known[4*sel+2], stat_present[4*sel+2]),
                enc(stat_known[4*sel+1], stat_present[4*sel+1]),
                enc(stat_known[4*sel], stat_present[4*sel])};

    // channel capture; address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_q.aw_got = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_q.w_got = 1'b1;
      next_q.w_data = s_axi_wdata;
      next_q.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end

    wr_fire = q.aw_got && q.w_got && !q.bvalid;
    do_cmd = wr_fire && (waddr == vcs_pkg::CMD_OFS);
    cmd = merge(32'h0, q.w_data, q.w_strb);
    cop = cmd[vcs_pkg::CMD_OP_LSB +: 4];
    cin = cmd[vcs_pkg::CMD_IN_LSB +: 4];
    cout = cmd[vcs_pkg::CMD_OUT_LSB +: 4];
    ii = 3'(cin - 4'h1);
    oi = 3'(cout - 4'h1);

    if (wr_fire) begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = vcs_pkg::RESP_OKAY;
      if (waddr == vcs_pkg::CMD_OFS) begin
        set[vcs_pkg::INT_DONE] = 1'b1;
        case (vcs_pkg::vcs_op_e'(cop))
          vcs_pkg::VCS_SWITCH: begin
            if (!in_range(cin, vcs_pkg::NUM_IN) ||
                !in_range(cout, NUM_OUT)) begin
              ref_flag = 1'b1;
            end else if (q.out_lock[oi]) begin
              ref_flag = 1'b1;
            end else begin
              next_q.route[oi] = cin;
              set[vcs_pkg::INT_ROUTE] = 1'b1;
            end
          end
          vcs_pkg::VCS_ROUTE_EVERY_OUTPUT: begin
            if (cin == vcs_pkg::NO_INPUT ||
                in_range(cin, vcs_pkg::NUM_IN)) begin
              for (int o = 0; o < NUM_OUT; o++) begin
                if (q.out_lock[o]) begin
                  ref_flag = 1'b1;
                end else begin
                  next_q.route[o] = cin;
                  set[vcs_pkg::INT_ROUTE] = 1'b1;
                end
              end
            end else begin
              ref_flag = 1'b1;
            end
          end
          vcs_pkg::VCS_SILENCE_INPUT, vcs_pkg::VCS_UNSILENCE_INPUT,
          vcs_pkg::VCS_FREEZE_INPUT, vcs_pkg::VCS_UNFREEZE_INPUT,
          vcs_pkg::VCS_SET_INPUT_PROTECT: begin
            if (!in_range(cin, vcs_pkg::NUM_IN)) begin
              ref_flag = 1'b1;
            end else if (cop == 4'(vcs_pkg::VCS_SILENCE_INPUT)) begin
              next_q.in_mute[ii] = 1'b1;
            end else if (cop == 4'(vcs_pkg::VCS_UNSILENCE_INPUT)) begin
              next_q.in_mute[ii] = 1'b0;
            end else if (cop == 4'(vcs_pkg::VCS_FREEZE_INPUT)) begin
              next_q.in_lock[ii] = 1'b1;
            end else if (cop == 4'(vcs_pkg::VCS_UNFREEZE_INPUT)) begin
              next_q.in_lock[ii] = 1'b0;
            end else begin
              next_q.in_prot[ii] = cmd[vcs_pkg::CMD_VAL_BIT];
            end
          end
          vcs_pkg::VCS_SILENCE_OUTPUT, vcs_pkg::VCS_UNSILENCE_OUTPUT,
          vcs_pkg::VCS_FREEZE_OUTPUT, vcs_pkg::VCS_UNFREEZE_OUTPUT,
          vcs_pkg::VCS_SET_OUTPUT_PROTECT: begin
            if (!in_range(cout, NUM_OUT)) begin
              ref_flag = 1'b1;
            end else if (cop == 4'(vcs_pkg::VCS_SILENCE_OUTPUT)) begin
              next_q.out_mute[oi] = 1'b1;
            end else if (cop == 4'(vcs_pkg::VCS_UNSILENCE_OUTPUT)) begin
              next_q.out_mute[oi] = 1'b0;
            end else if (cop == 4'(vcs_pkg::VCS_FREEZE_OUTPUT)) begin
              next_q.out_lock[oi] = 1'b1;
            end else if (cop == 4'(vcs_pkg::VCS_UNFREEZE_OUTPUT)) begin
              next_q.out_lock[oi] = 1'b0;
            end else begin
              next_q.out_mode[oi] = cmd[vcs_pkg::CMD_VAL_BIT];
            end
          end
          default: ref_flag = 1'b1;
        endcase
        // every command, refused or not, is echoed back
        next_q.ack_echo = cmd[12:0];
        next_q.ack_ref = ref_flag;
        set[vcs_pkg::INT_REFUSED] = ref_flag;
      end else if (waddr == vcs_pkg::INT_STATUS_OFS) begin
        clr = q.w_data[2:0] & {3{q.w_strb[0]}};
      end else if (waddr == vcs_pkg::INT_MASK_OFS) begin
        next_q.imask = 3'(merge({29'h0, q.imask}, q.w_data, q.w_strb));
      end else if (waddr == vcs_pkg::REPORT_SEL_OFS) begin
        next_q.rsel = 3'(merge({29'h0, q.rsel}, q.w_data, q.w_strb));
      end else if (waddr == vcs_pkg::ROUTE_OFS ||
                   waddr == vcs_pkg::FLAGS_OFS ||
                   waddr == vcs_pkg::PROTECT_OFS ||
                   waddr == vcs_pkg::ACK_OFS ||
                   waddr == vcs_pkg::REPORT_OFS) begin
        next_q.bresp = vcs_pkg::RESP_OKAY;
      end else begin
        next_q.bresp = vcs_pkg::RESP_SLVERR;
      end
    end

    // set wins over a clear in the same cycle
    next_q.ist = (q.ist & ~clr) | set;

    // unbuilt outputs stay disconnected
    for (int o = 0; o < vcs_pkg::MAX_OUT; o++) begin
      if (o >= NUM_OUT) begin
        next_q.route[o] = vcs_pkg::NO_INPUT;
      end
    end

    // blanking leaves the stored route untouched
    for (int o = 0; o < vcs_pkg::MAX_OUT; o++) begin
      ri = 3'(next_q.route[o] - 4'h1);
      next_q.blank[o] = next_q.out_mute[o] ||
        (next_q.route[o] != vcs_pkg::NO_INPUT &&
         next_q.in_mute[ri]);
    end

    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = vcs_pkg::RESP_OKAY;
      if (raddr == vcs_pkg::ROUTE_OFS) begin
        next_q.rdata = q.route;
      end else if (raddr == vcs_pkg::FLAGS_OFS) begin
        next_q.rdata = {q.out_lock, q.out_mute, q.in_lock, q.in_mute};
      end else if (raddr == vcs_pkg::PROTECT_OFS) begin
        next_q.rdata = {16'h0, q.out_mode, q.in_prot};
      end else if (raddr == vcs_pkg::ACK_OFS) begin
        next_q.rdata = {15'h0, q.ack_ref, 3'h0, q.ack_echo};
      end else if (raddr == vcs_pkg::INT_STATUS_OFS) begin
        next_q.rdata = {29'h0, q.ist};
      end else if (raddr == vcs_pkg::INT_MASK_OFS) begin
        next_q.rdata = {29'h0, q.imask};
      end else if (raddr == vcs_pkg::REPORT_SEL_OFS) begin
        next_q.rdata = {29'h0, q.rsel};
      end else if (raddr == vcs_pkg::REPORT_OFS) begin
        next_q.rdata = rep_word;
      end else if (raddr == vcs_pkg::CMD_OFS) begin
        next_q.rdata = 32'h0;
      end else begin
        next_q.rdata = 32'h0;
        next_q.rresp = vcs_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.imask <= vcs_pkg::INT_MASK_RST;
      q.in_prot <= vcs_pkg::IN_PROTECT_RST;
      q.out_mode <= vcs_pkg::OUT_PROTECT_RST;
    end else if (ce) begin
      q <= next_q;
    end
  end

  // handshakes gated by ce so no beat is taken while frozen
  assign s_axi_awready = ce && !q.aw_got && !q.bvalid;
  assign s_axi_wready = ce && !q.w_got && !q.bvalid;
  assign s_axi_bvalid = ce && q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = ce && !q.rvalid;
  assign s_axi_rvalid = ce && q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign route_out = q.route;
  assign blank_out = q.blank;
  assign irq = |(q.ist & q.imask);

  switch_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && do_cmd && cop == 4'(vcs_pkg::VCS_SWITCH) &&
     in_range(cin, vcs_pkg::NUM_IN) && in_range(cout, NUM_OUT) &&
     !q.out_lock[3'(cout - 4'h1)])
    |=> q.route[3'($past(cout) - 4'h1)] == $past(cin))
    else $error("switch did not set route");

  route_all_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && do_cmd && cop == 4'(vcs_pkg::VCS_ROUTE_EVERY_OUTPUT) &&
     in_range(cin, vcs_pkg::NUM_IN) && !q.out_lock[0])
    |=> q.route[0] == $past(cin))
    else $error("route every output missed output one");

  clear_all_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && do_cmd && cop == 4'(vcs_pkg::VCS_ROUTE_EVERY_OUTPUT) &&
     cin == 4'h0 && q.out_lock == 8'h00)
    |=> q.route == 32'h0)
    else $error("disconnect all left a route");

  lock_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && do_cmd && cop == 4'(vcs_pkg::VCS_SWITCH) &&
     in_range(cout, NUM_OUT) && q.out_lock[3'(cout - 4'h1)])
    |=> $stable(q.route) && q.ack_ref)
    else $error("locked output changed");

  in_mute_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && do_cmd && cop == 4'(vcs_pkg::VCS_SILENCE_INPUT) &&
     in_range(cin, vcs_pkg::NUM_IN))
    |=> q.in_mute[3'($past(cin) - 4'h1)] ##0 q.ist[vcs_pkg::INT_DONE])
    else $error("input mute not set");

  out_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && do_cmd && cop == 4'(vcs_pkg::VCS_FREEZE_OUTPUT) &&
     in_range(cout, NUM_OUT))
    |=> q.out_lock[3'($past(cout) - 4'h1)])
    else $error("output lock not set");

  blank_mute_a: assert property (@(posedge clk) disable iff (!rst_n)
    q.out_mute[0] |-> blank_out[0])
    else $error("muted output not blanked");

  report_rsv_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && s_axi_arvalid && s_axi_arready &&
     {s_axi_araddr[7:2], 2'b00} == vcs_pkg::REPORT_OFS)
    |=> q.rdata[15:8] == 8'h00 && q.rdata[23:16] != 8'h00)
    else $error("report reserved byte not zero");

  bresp_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.bvalid && !(ce && s_axi_bready)) |=> q.bvalid && $stable(q.bresp))
    else $error("write response dropped early");

  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && do_cmd && q.imask[vcs_pkg::INT_DONE]) |=> irq)
    else $error("command done did not raise interrupt");

  switch_c: cover property (@(posedge clk) disable iff (!rst_n)
    ce && do_cmd && cop == 4'(vcs_pkg::VCS_SWITCH) && !q.ack_ref);
  refused_c: cover property (@(posedge clk) disable iff (!rst_n)
    ce && do_cmd ##1 q.ack_ref);
  report_c: cover property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid && s_axi_rready && q.rdata[23:16] == vcs_pkg::LET_BOTH);

endmodule // vcs_xpoint

// ### tb/vcs_host.sv
`timescale 1ns/1ps
module vcs_host (
  input wire logic clk, // system clock
  output logic [7:0] s_axi_awaddr, // write address
  output logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  output logic [31:0] s_axi_wdata, // write data
  output logic [3:0] s_axi_wstrb, // byte strobes
  output logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // response valid
  output logic s_axi_bready, // response ready
  output logic [7:0] s_axi_araddr, // read address
  output logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  output logic s_axi_rready // read data ready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end

  // handshakes judged at the falling edge, where readies are settled;
  // released payload is inverted so no stale value can pass as live
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bready && s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (tb) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tr;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rready && s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (tr) s_axi_rready <= 1'b0;
    end
  endtask
endmodule // vcs_host

// ### tb/vcs_xpoint_tb.sv
`timescale 1ns/1ps
module vcs_xpoint_tb;
  logic clk, rst_n, ce, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, blank_out;
  logic [31:0] s_axi_wdata, s_axi_rdata, route_out;
  logic [31:0] stat_known, stat_present;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int fails, comparisons;

  // four-output build: upper route nibbles must stay empty
  vcs_xpoint #(.NUM_OUT(4)) i_dut (.*);
  vcs_host i_host (.*);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop;
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wchk(logic [7:0] a, logic [31:0] d, logic [1:0] e);
    logic [1:0] r;
    i_host.wr(a, d, r);
    chk("bresp", 32'(e), 32'(r));
  endtask

  task automatic rchk(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_host.rd(a, d, r);
    chk("rresp", 32'(er), 32'(r));
    chk("rdata", e, d);
  endtask

  task automatic cmd(vcs_pkg::vcs_op_e op, logic [3:0] i, logic [3:0] o,
                     logic v, logic rf);
    logic [31:0] w;
    w = {19'h0, v, o, i, op};
    wchk(vcs_pkg::CMD_OFS, w, vcs_pkg::RESP_OKAY);
    rchk(vcs_pkg::ACK_OFS, {15'h0, rf, 3'h0, w[12:0]}, vcs_pkg::RESP_OKAY);
  endtask

  task automatic pins(logic [31:0] rt, logic [7:0] bl, logic iq);
    @(negedge clk);
    chk("route_out", rt, route_out);
    chk("blank_out", 32'(bl), 32'(blank_out));
    chk("irq", 32'(iq), 32'(irq));
  endtask

  task automatic t_reset;
    rchk(vcs_pkg::ROUTE_OFS, 32'h0, vcs_pkg::RESP_OKAY);
    rchk(vcs_pkg::FLAGS_OFS, 32'h0, vcs_pkg::RESP_OKAY);
    rchk(vcs_pkg::PROTECT_OFS, 32'h0000_00ff, vcs_pkg::RESP_OKAY);
    rchk(vcs_pkg::INT_MASK_OFS, 32'h0, vcs_pkg::RESP_OKAY);
    pins(32'h0, 8'h00, 1'b0);
  endtask

  task automatic t_route;
    cmd(vcs_pkg::VCS_SWITCH, 4'h4, 4'h1, 1'b0, 1'b0);
    cmd(vcs_pkg::VCS_SWITCH, 4'h1, 4'h2, 1'b0, 1'b0);
    cmd(vcs_pkg::VCS_SWITCH, 4'h8, 4'h3, 1'b0, 1'b0);
    cmd(vcs_pkg::VCS_SWITCH, 4'h8, 4'h4, 1'b0, 1'b0);
    rchk(vcs_pkg::ROUTE_OFS, 32'h0000_8814, vcs_pkg::RESP_OKAY);
    cmd(vcs_pkg::VCS_SWITCH, 4'h1, 4'h5, 1'b0, 1'b1);
    pins(32'h0000_8814, 8'h00, 1'b0);
    cmd(vcs_pkg::VCS_ROUTE_EVERY_OUTPUT, 4'h3, 4'h0, 1'b0, 1'b0);
    pins(32'h0000_3333, 8'h00, 1'b0);
    cmd(vcs_pkg::VCS_ROUTE_EVERY_OUTPUT, 4'h0, 4'h0, 1'b0, 1'b0);
    rchk(vcs_pkg::ROUTE_OFS, 32'h0, vcs_pkg::RESP_OKAY);
  endtask

  // each set op is followed by its clear op; port 2 in both fields
  task automatic t_flags;
    int sh[4] = '{0, 16, 8, 24};
    for (int i = 0; i < 8; i++) begin
      cmd(vcs_pkg::vcs_op_e'(2 + i), 4'h2, 4'h2, 1'b0, 1'b0);
      rchk(vcs_pkg::FLAGS_OFS, i[0] ? 32'h0 : 32'h2 << sh[i / 2],
           vcs_pkg::RESP_OKAY);
    end
  endtask

  task automatic t_blank;
    cmd(vcs_pkg::VCS_ROUTE_EVERY_OUTPUT, 4'h2, 4'h0, 1'b0, 1'b0);
    cmd(vcs_pkg::VCS_SILENCE_INPUT, 4'h2, 4'h1, 1'b0, 1'b0);
    pins(32'h0000_2222, 8'h0f, 1'b0);
    cmd(vcs_pkg::VCS_UNSILENCE_INPUT, 4'h2, 4'h1, 1'b0, 1'b0);
    cmd(vcs_pkg::VCS_SILENCE_OUTPUT, 4'h1, 4'h3, 1'b0, 1'b0);
    pins(32'h0000_2222, 8'h04, 1'b0);
    cmd(vcs_pkg::VCS_UNSILENCE_OUTPUT, 4'h1, 4'h3, 1'b0, 1'b0);
    pins(32'h0000_2222, 8'h00, 1'b0);
  endtask

  task automatic t_lock;
    cmd(vcs_pkg::VCS_FREEZE_OUTPUT, 4'h1, 4'h1, 1'b0, 1'b0);
    cmd(vcs_pkg::VCS_SWITCH, 4'h5, 4'h1, 1'b0, 1'b1);
    cmd(vcs_pkg::VCS_ROUTE_EVERY_OUTPUT, 4'h6, 4'h0, 1'b0, 1'b1);
    pins(32'h0000_6662, 8'h00, 1'b0);
    cmd(vcs_pkg::VCS_UNFREEZE_OUTPUT, 4'h1, 4'h1, 1'b0, 1'b0);
    cmd(vcs_pkg::VCS_SWITCH, 4'h7, 4'h1, 1'b0, 1'b0);
    pins(32'h0000_6667, 8'h00, 1'b0);
  endtask

  task automatic t_protect;
    cmd(vcs_pkg::VCS_SET_INPUT_PROTECT, 4'h1, 4'h1, 1'b0, 1'b0);
    cmd(vcs_pkg::VCS_SET_OUTPUT_PROTECT, 4'h2, 4'h2, 1'b1, 1'b0);
    rchk(vcs_pkg::PROTECT_OFS, 32'h0000_02fe, vcs_pkg::RESP_OKAY);
    cmd(vcs_pkg::VCS_SET_OUTPUT_PROTECT, 4'h2, 4'h2, 1'b0, 1'b0);
    cmd(vcs_pkg::VCS_SET_INPUT_PROTECT, 4'h1, 4'h1, 1'b1, 1'b0);
    rchk(vcs_pkg::PROTECT_OFS, 32'h0000_00ff, vcs_pkg::RESP_OKAY);
  endtask

  // input 2: audio present, crypt absent, signal unknown, link present
  task automatic t_report;
    logic [7:0] lt[4] = '{8'h54, 8'h4c, 8'h4d, 8'h55};
    stat_known <= 32'h0000_00df;
    stat_present <= 32'h0000_0090;
    wchk(vcs_pkg::REPORT_SEL_OFS, 32'h1, vcs_pkg::RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      cmd(k[1] ? vcs_pkg::VCS_SILENCE_INPUT : vcs_pkg::VCS_UNSILENCE_INPUT,
          4'h2, 4'h1, 1'b0, 1'b0);
      cmd(k[0] ? vcs_pkg::VCS_FREEZE_INPUT : vcs_pkg::VCS_UNFREEZE_INPUT,
          4'h2, 4'h1, 1'b0, 1'b0);
      rchk(vcs_pkg::REPORT_OFS, {8'h00, lt[k], 16'h00e3},
           vcs_pkg::RESP_OKAY);
    end
    wchk(vcs_pkg::REPORT_SEL_OFS, 32'h0, vcs_pkg::RESP_OKAY);
    rchk(vcs_pkg::REPORT_OFS, 32'h0054_00aa, vcs_pkg::RESP_OKAY);
  endtask

  task automatic t_irq;
    wchk(vcs_pkg::INT_STATUS_OFS, 32'h7, vcs_pkg::RESP_OKAY);
    rchk(vcs_pkg::INT_STATUS_OFS, 32'h0, vcs_pkg::RESP_OKAY);
    cmd(vcs_pkg::VCS_UNSILENCE_INPUT, 4'h3, 4'h1, 1'b0, 1'b0);
    pins(32'h0000_6667, 8'h00, 1'b0);
    wchk(vcs_pkg::INT_MASK_OFS, 32'h5, vcs_pkg::RESP_OKAY);
    rchk(vcs_pkg::INT_MASK_OFS, 32'h5, vcs_pkg::RESP_OKAY);
    pins(32'h0000_6667, 8'h00, 1'b1);
    wchk(vcs_pkg::INT_STATUS_OFS, 32'h1, vcs_pkg::RESP_OKAY);
    pins(32'h0000_6667, 8'h00, 1'b0);
    cmd(vcs_pkg::vcs_op_e'(4'hf), 4'h1, 4'h1, 1'b0, 1'b1);
    rchk(vcs_pkg::INT_STATUS_OFS, 32'h5, vcs_pkg::RESP_OKAY);
    pins(32'h0000_6667, 8'h00, 1'b1);
    wchk(vcs_pkg::INT_STATUS_OFS, 32'h7, vcs_pkg::RESP_OKAY);
    pins(32'h0000_6667, 8'h00, 1'b0);
    wchk(8'h40, 32'h1, vcs_pkg::RESP_SLVERR);
    rchk(8'h40, 32'h0, vcs_pkg::RESP_SLVERR);
  endtask

  // ce low must hold every register and refuse bus beats
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    fork
      cmd(vcs_pkg::VCS_SWITCH, 4'h1, 4'h2, 1'b0, 1'b0);
      begin
        repeat (4) begin
          @(negedge clk);
          chk("route_out", 32'h0000_6667, route_out);
          chk("awready", 32'h0, 32'(s_axi_awready));
        end
        @(posedge clk);
        ce <= 1'b1;
      end
    join
    pins(32'h0000_6617, 8'h00, 1'b1);
  endtask

  initial begin
    fails = 0;
    comparisons = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    stat_known = 32'h0;
    stat_present = 32'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_route();
    t_flags();
    t_blank();
    t_lock();
    t_protect();
    t_report();
    t_irq();
    t_freeze();
    report_and_stop();
  end

  // whole run needs a few hundred cycles; this is dozens of times that
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end
endmodule // vcs_xpoint_tb
